/* File: hdl/mmrc_pkg.sv */
package mmrc_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SOFT_RST = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_PERIOD_SEL = 8'h0c;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int MODE_W = 5;
    localparam int SOFT_RESET_BIT_BIT = 0;
    localparam logic [4:0] MODE_RST = 5'h00;
    // ------------------------------------------------------------
    // mode codes
    // ------------------------------------------------------------
    localparam logic [4:0] MODE_PDN = 5'h00;
    localparam logic [4:0] MODE_SINGLE = 5'h01;
    localparam logic [4:0] MODE_CONT1 = 5'h02;
    localparam logic [4:0] MODE_CONT2 = 5'h04;
    localparam logic [4:0] MODE_CONT3 = 5'h06;
    localparam logic [4:0] MODE_CONT4 = 5'h08;
    localparam logic [4:0] MODE_CONT5 = 5'h0a;
    localparam logic [4:0] MODE_CONT6 = 5'h0c;
    localparam logic [4:0] MODE_SELFTEST = 5'h10;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int MEAS_TIME_US = 45;
    localparam int MEAS_CYC = MEAS_TIME_US * CLK_MHZ;
    localparam int SOFT_RESET_BIT_CYC = 4;
    typedef enum logic [1:0] {
        ST_PDN = 2'b00,
        ST_MEAS = 2'b01,
        ST_IDLE = 2'b10,
        ST_RST = 2'b11
    } mmrc_state_t;
endpackage

/* File: hdl/mmrc_timer_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface mmrc_timer_if;
    logic start;
    logic [31:0] load;
    logic expired;
    modport ctrl (output start, output load, input expired);
    modport tmr (input start, input load, output expired);
endinterface
`default_nettype wire

/* File: hdl/mmrc_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module mmrc_timer (
    input wire logic pclk,
    input wire logic rst_n,
    input wire logic ce,
    mmrc_timer_if.tmr t
);
    logic [31:0] cnt_ff;
    // expired while the count stands at one; start reloads. expired must
    // not look at start, or the controller's restart closes a comb loop
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 32'h0;
        end else if (ce) begin
            if (t.start) begin
                cnt_ff <= t.load;
            end else if (cnt_ff != 32'h0) begin
                cnt_ff <= cnt_ff - 32'h1;
            end
        end
    end
    assign t.expired = cnt_ff == 32'h1;
endmodule
`default_nettype wire

/* File: hdl/mmrc_ctrl.sv */
//
// Summary of operation
// (RULE_01) power-on reset initialises, then power-down
// (RULE_02) interface supply off holds reset
// (RULE_03) low external reset input resets device
// (RULE_04) soft reset bit resets like others
// (RULE_05) after reset: defaults, power-down, no host
// (RULE_06) nine modes from five-bit mode field
// (RULE_07) defined code switches mode and starts it
// (RULE_08) host goes via power-down between modes
// (RULE_09) host waits 100 us after power-down
// (RULE_10) power-down gates circuits, registers stay accessible
// (RULE_11) power-down retains registers until reset
// (RULE_12) single measurement returns to power-down, 00000
// (RULE_13) six continuous codes give six rates
// (RULE_14) self-test measures then returns to power-down
// (RULE_15) soft reset bit clears itself
// (RULE_16) undefined mode codes are ignored
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module mmrc_ctrl #(
    parameter int MEAS_CYCLES = mmrc_pkg::MEAS_CYC,
    parameter int PER_10HZ = 12500000,
    parameter int PER_20HZ = 6250000,
    parameter int PER_50HZ = 2500000,
    parameter int PER_100HZ = 1250000,
    parameter int PER_200HZ = 625000,
    parameter int PER_1HZ = 125000000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic por_n,
    input wire logic vid_ok,
    input wire logic external_reset_input_low,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic circuits_on,
    output logic meas_active,
    output logic meas_done,
    output logic self_test_src,
    output logic in_reset
);
    // ------------------------------------------------------------
    // reset merge
    // ------------------------------------------------------------
    logic soft_reset_bit_req_ff;
    logic [2:0] soft_reset_bit_cnt_ff;
    logic rst_src_n;
    logic soft_rst;
    logic ext_rst_n;
    // all hardware sources reach the flops asynchronously
    assign ext_rst_n = presetn && por_n && vid_ok // RULE_01 RULE_02
        && external_reset_input_low; // RULE_03
    assign soft_rst = soft_reset_bit_req_ff; // RULE_04
    assign rst_src_n = ext_rst_n;
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [4:0] mode_control_register_ff;
    logic [4:0] nxt_mode;
    mmrc_pkg::mmrc_state_t state_ff, nxt_state;
    logic [31:0] period_ff;
    logic wr_en, rd_en;
    logic mode_wr;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign mode_wr = wr_en && paddr == mmrc_pkg::ADDR_MODE_CTRL;
    function automatic logic mode_defined(input logic [4:0] m);
        case (m)
            mmrc_pkg::MODE_PDN, mmrc_pkg::MODE_SINGLE,
            mmrc_pkg::MODE_CONT1, mmrc_pkg::MODE_CONT2,
            mmrc_pkg::MODE_CONT3, mmrc_pkg::MODE_CONT4,
            mmrc_pkg::MODE_CONT5, mmrc_pkg::MODE_CONT6,
            mmrc_pkg::MODE_SELFTEST: mode_defined = 1'b1; // RULE_06
            default: mode_defined = 1'b0;
        endcase
    endfunction
    function automatic logic [31:0] mode_period(input logic [4:0] m);
        case (m)
            mmrc_pkg::MODE_CONT1: mode_period = 32'(PER_10HZ); // RULE_13
            mmrc_pkg::MODE_CONT2: mode_period = 32'(PER_20HZ);
            mmrc_pkg::MODE_CONT3: mode_period = 32'(PER_50HZ);
            mmrc_pkg::MODE_CONT4: mode_period = 32'(PER_100HZ);
            mmrc_pkg::MODE_CONT5: mode_period = 32'(PER_200HZ);
            mmrc_pkg::MODE_CONT6: mode_period = 32'(PER_1HZ);
            default: mode_period = 32'h0;
        endcase
    endfunction
    function automatic logic is_cont(input logic [4:0] m);
        is_cont = mode_period(m) != 32'h0;
    endfunction
    // ------------------------------------------------------------
    // soft reset: a short internal pulse, then the bit clears
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge rst_src_n) begin
        if (!rst_src_n) begin
            soft_reset_bit_req_ff <= 1'b0;
            soft_reset_bit_cnt_ff <= 3'h0;
        end else if (ce) begin
            if (soft_reset_bit_req_ff) begin
                soft_reset_bit_cnt_ff <= soft_reset_bit_cnt_ff + 3'h1;
                if (soft_reset_bit_cnt_ff == 3'(mmrc_pkg::SOFT_RESET_BIT_CYC - 1)) begin
                    soft_reset_bit_req_ff <= 1'b0; // RULE_15
                    soft_reset_bit_cnt_ff <= 3'h0;
                end
            end else if (wr_en && paddr == mmrc_pkg::ADDR_SOFT_RST
                    && pwdata[mmrc_pkg::SOFT_RESET_BIT_BIT]) begin
                soft_reset_bit_req_ff <= 1'b1; // RULE_04
            end
        end
    end
    // ------------------------------------------------------------
    // measurement timer
    // ------------------------------------------------------------
    mmrc_timer_if tif ();
    mmrc_timer u_tmr (
        .pclk(pclk),
        .rst_n(rst_src_n),
        .ce(ce),
        .t(tif.tmr)
    );
    logic mode_go;
    assign mode_go = mode_wr && mode_defined(pwdata[4:0]) // RULE_16
        && pwdata[4:0] != mmrc_pkg::MODE_PDN;
    always_comb begin
        tif.start = 1'b0;
        tif.load = 32'(MEAS_CYCLES);
        if (soft_rst) begin
            tif.start = 1'b0;
        end else if (mode_go) begin
            tif.start = 1'b1; // RULE_07
        end else if (state_ff == mmrc_pkg::ST_IDLE && tif.expired) begin
            tif.start = 1'b1;
        end else if (state_ff == mmrc_pkg::ST_MEAS && tif.expired
                && is_cont(mode_control_register_ff)) begin
            // remaining part of the period is spent idle
            tif.start = 1'b1;
            tif.load = period_ff - 32'(MEAS_CYCLES);
        end
    end
    // ------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_mode = mode_control_register_ff;
        case (state_ff)
            mmrc_pkg::ST_RST: begin
                nxt_state = mmrc_pkg::ST_PDN; // RULE_05
            end
            mmrc_pkg::ST_PDN, mmrc_pkg::ST_MEAS, mmrc_pkg::ST_IDLE: begin
                if (state_ff == mmrc_pkg::ST_MEAS && tif.expired) begin
                    if (is_cont(mode_control_register_ff)) begin
                        nxt_state = mmrc_pkg::ST_IDLE;
                    end else begin
                        nxt_state = mmrc_pkg::ST_PDN; // RULE_12 RULE_14
                        nxt_mode = mmrc_pkg::MODE_PDN;
                    end
                end
                if (state_ff == mmrc_pkg::ST_IDLE && tif.expired) begin
                    nxt_state = mmrc_pkg::ST_MEAS;
                end
                if (mode_wr && mode_defined(pwdata[4:0])) begin // RULE_16
                    nxt_mode = pwdata[4:0]; // RULE_07
                    nxt_state = (pwdata[4:0] == mmrc_pkg::MODE_PDN) ?
                        mmrc_pkg::ST_PDN : mmrc_pkg::ST_MEAS;
                end
            end
            default: begin
                nxt_state = mmrc_pkg::ST_PDN;
            end
        endcase
        if (soft_rst) begin
            nxt_state = mmrc_pkg::ST_RST; // RULE_04
            nxt_mode = mmrc_pkg::MODE_RST;
        end
    end
    // registers keep contents across power-down; resets clear them, and a finished single or self-test sets the mode to 00000
    always_ff @(posedge pclk or negedge rst_src_n) begin
        if (!rst_src_n) begin
            state_ff <= mmrc_pkg::ST_RST; // RULE_01 RULE_05
            mode_control_register_ff <= mmrc_pkg::MODE_RST; // RULE_11
        end else if (ce) begin
            state_ff <= nxt_state;
            mode_control_register_ff <= nxt_mode;
        end
    end
    always_ff @(posedge pclk or negedge rst_src_n) begin
        if (!rst_src_n) begin
            period_ff <= 32'h0;
        end else if (ce) begin
            if (soft_rst) begin
                period_ff <= 32'h0;
            end else if (mode_wr && is_cont(pwdata[4:0])) begin
                period_ff <= mode_period(pwdata[4:0]); // RULE_13
            end
        end
    end
    // ------------------------------------------------------------
    // apb read side; registers answer in every state
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge rst_src_n) begin
        if (!rst_src_n) begin
            prdata <= 32'h0;
        end else if (ce && psel && !penable && !pwrite) begin
            case (paddr)
                mmrc_pkg::ADDR_MODE_CTRL: // RULE_10
                    prdata <= {27'h0, mode_control_register_ff};
                mmrc_pkg::ADDR_SOFT_RST:
                    prdata <= {31'h0, soft_reset_bit_req_ff};
                mmrc_pkg::ADDR_STATUS:
                    prdata <= {30'h0, state_ff};
                mmrc_pkg::ADDR_PERIOD_SEL:
                    prdata <= period_ff;
                default:
                    prdata <= 32'h0;
            endcase
        end
    end
    always_comb begin
        case (paddr)
            mmrc_pkg::ADDR_MODE_CTRL, mmrc_pkg::ADDR_SOFT_RST,
            mmrc_pkg::ADDR_STATUS, mmrc_pkg::ADDR_PERIOD_SEL:
                pslverr = 1'b0;
            default:
                pslverr = psel && penable;
        endcase
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic done_ff;
    always_ff @(posedge pclk or negedge rst_src_n) begin
        if (!rst_src_n) begin
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= state_ff == mmrc_pkg::ST_MEAS && tif.expired;
        end
    end
    assign meas_done = done_ff;
    assign meas_active = state_ff == mmrc_pkg::ST_MEAS;
    assign circuits_on = meas_active; // RULE_10
    assign self_test_src = meas_active
        && mode_control_register_ff == mmrc_pkg::MODE_SELFTEST; // RULE_14
    assign in_reset = state_ff == mmrc_pkg::ST_RST;
    logic unused_rd;
    assign unused_rd = rd_en;
endmodule
`default_nettype wire

/* File: bench/mmrc_ctrl_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module mmrc_ctrl_assertions #(
    parameter int MEAS_CYCLES = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic por_n,
    input wire logic vid_ok,
    input wire logic external_reset_input_low,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic circuits_on,
    input wire logic meas_active,
    input wire logic meas_done,
    input wire logic self_test_src,
    input wire logic in_reset
);
    // two cycles of slack: the done pulse may trail the state by one
    localparam int LO = MEAS_CYCLES - 2;
    localparam int HI = MEAS_CYCLES + 2;
    logic [15:0] run_ff;
    wire logic rst_any = !presetn || !por_n || !vid_ok
        || !external_reset_input_low;
    wire logic mw = psel && penable && pwrite && paddr == 8'h00;
    wire logic [4:0] mc = pwdata[4:0];
    wire logic go = mc inside {5'h01, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0a,
        5'h0c, 5'h10};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= 16'h0000;
        end else begin
            run_ff <= meas_active ? run_ff + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (rst_any);
    a_reset_holds: assert property (disable iff (!presetn)
        !por_n || !vid_ok || !external_reset_input_low |-> in_reset)
        else $error("reset source low but block not in reset");
    a_reset_exits: assert property (in_reset |-> ##[1:8] !in_reset)
        else $error("block stuck in reset");
    a_done_timing: assert property (meas_done |-> run_ff >= LO)
        else $error("measurement ended early");
    a_meas_bounded: assert property (meas_active |-> run_ff <= HI)
        else $error("measurement overran");
    a_done_pulse: assert property (meas_done |=> !meas_done)
        else $error("done pulse longer than one cycle");
    a_selftest_src: assert property (self_test_src |-> meas_active)
        else $error("test source on outside a measurement");
    a_power_gating: assert property (circuits_on == meas_active)
        else $error("circuits on while not measuring");
    a_mode_starts: assert property (
        ce && mw && go && !meas_active && !in_reset |=> meas_active)
        else $error("defined mode code did not start");
    a_undef_ignored: assert property (
        mw && !go && mc != 5'h00 && !meas_active |=> !meas_active)
        else $error("undefined mode code acted on");
    a_pdn_stops: assert property (
        mw && mc == 5'h00 |=> !meas_active [*2])
        else $error("power-down code did not stop");
endmodule
bind mmrc_ctrl mmrc_ctrl_assertions #(.MEAS_CYCLES(MEAS_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .por_n(por_n), .vid_ok(vid_ok),
    .external_reset_input_low(external_reset_input_low), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .circuits_on(circuits_on), .meas_active(meas_active),
    .meas_done(meas_done), .self_test_src(self_test_src),
    .in_reset(in_reset));
`default_nettype wire

/* File: bench/mmrc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module mmrc_host (
    input wire logic pclk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    logic [32:0] exp_q[$];
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // leading edge wait keeps back-to-back calls from double driving psel
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [32:0] e);
        @(posedge pclk);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: bench/magnetometer_mode_reset_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module magnetometer_mode_reset_control_tb;
    localparam int TWAIT = 12500;
    localparam int MEAS = 20;
    // short periods in cycles so every continuous rate fits the run
    localparam int PERS [8] = '{0, 0, 400, 200, 80, 40, 30, 1000};
    logic pclk = 1'b0;
    logic ce = 1'b1;
    logic presetn = 1'b0;
    logic [2:0] rs_n = 3'b111;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic circuits_on, meas_active, meas_done, self_test_src, in_reset;
    logic [31:0] seed = 32'h3f09b493;
    logic [4:0] codes [8] = '{5'h01, 5'h10, 5'h02, 5'h04, 5'h06, 5'h08,
        5'h0a, 5'h0c};
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;
    always #4 pclk = ~pclk;
    mmrc_ctrl #(.MEAS_CYCLES(MEAS), .PER_10HZ(PERS[2]), .PER_20HZ(PERS[3]),
        .PER_50HZ(PERS[4]), .PER_100HZ(PERS[5]), .PER_200HZ(PERS[6]),
        .PER_1HZ(PERS[7]))
    u_mmrc_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce),
        .por_n(rs_n[2]), .vid_ok(rs_n[1]),
        .external_reset_input_low(rs_n[0]), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .circuits_on(circuits_on),
        .meas_active(meas_active), .meas_done(meas_done),
        .self_test_src(self_test_src), .in_reset(in_reset));
    mmrc_host u_mmrc_host (.pclk(pclk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        u_mmrc_host.xfer(1'b0, a, 32'h0, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_mmrc_host.xfer(1'b1, a, d, 33'h0);
    endtask
    task automatic wait_done();
        do @(posedge pclk); while (meas_done !== 1'b1);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // every finished transfer is matched against the oldest queued note
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (psel && penable && pready) begin
            check({pslverr, pwrite ? 32'h0 : prdata},
                u_mmrc_host.exp_q.pop_front());
        end
        if (cyc == 95000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 33'h0);
        rd(8'h08, 33'h0);
        rd(8'h10, {1'b1, 32'h0});
        $display("defaults test done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            wr(8'h00, {seed[31:5], codes[i]});
            rd(8'h00, {28'h0, codes[i]});
            check({32'h0, meas_active}, 33'h1);
            check({32'h0, circuits_on}, 33'h1);
            check({32'h0, self_test_src}, {32'h0, i == 1});
            if (i > 1) begin
                rd(8'h0c, {1'b0, 32'(PERS[i])});
            end
            wait_done();
            if (i < 2) begin
                rd(8'h00, 33'h0);
            end else begin
                n = 0;
                do begin
                    @(posedge pclk);
                    n++;
                end while (meas_done !== 1'b1);
                check({32'h0, n >= PERS[i] - 1 && n <= PERS[i] + 1},
                    33'h1);
                wr(8'h00, 32'h0);
                rd(8'h00, 33'h0);
                repeat (TWAIT) @(posedge pclk);
            end
            check({32'h0, meas_active}, 33'h0);
            check({32'h0, circuits_on}, 33'h0);
        end
        $display("modes test done");
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            wr(8'h00, {seed[31:5], seed[4:1] | 4'h1, 1'b1});
            rd(8'h00, 33'h0);
            check({32'h0, meas_active}, 33'h0);
        end
        $display("undefined code test done");
        // a write seen while the enable is low must leave no trace
        ce <= 1'b0;
        wr(8'h00, 32'h1);
        ce <= 1'b1;
        check({32'h0, meas_active}, 33'h0);
        rd(8'h00, 33'h0);
        $display("clock enable test done");
        wr(8'h00, 32'h2);
        wr(8'h04, 32'h1);
        rd(8'h04, 33'h1);
        repeat (6) @(posedge pclk);
        rd(8'h04, 33'h0);
        rd(8'h00, 33'h0);
        check({32'h0, meas_active}, 33'h0);
        for (int j = 0; j < 3; j++) begin
            wr(8'h00, 32'h2);
            rs_n[j] <= 1'b0;
            repeat (3) begin
                @(posedge pclk);
                check({32'h0, in_reset}, 33'h1);
            end
            rs_n[j] <= 1'b1;
            repeat (3) @(posedge pclk);
            check({31'h0, in_reset, meas_active}, 33'h0);
            rd(8'h00, 33'h0);
        end
        $display("reset test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
